// File: src/mlc_lab_top.sv
// Logic array block of sixteen macrocells with AXI4-Lite configuration
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module mlc_lab_top
  import mlc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        global_clock_pin_a,
  input  wire logic        global_clock_pin_b,
  input  wire logic        global_clear_pin_low,
  input  wire logic [15:0] array_pin_in,
  output logic [15:0]      mc_out
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0]  gpin_s1_reg;
  logic [1:0]  gpin_s2_reg;
  logic        gclr_s1_reg;
  logic        gclr_s2_reg;
  logic [15:0] in_s1_reg;
  logic [15:0] in_s2_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gpin_s1_reg <= 2'h0;
      gpin_s2_reg <= 2'h0;
      gclr_s1_reg <= 1'b1;
      gclr_s2_reg <= 1'b1;
      in_s1_reg   <= 16'h0000;
      in_s2_reg   <= 16'h0000;
    end
    else
    begin
      gpin_s1_reg <= {global_clock_pin_b, global_clock_pin_a};
      gpin_s2_reg <= gpin_s1_reg;
      gclr_s1_reg <= global_clear_pin_low;
      gclr_s2_reg <= gclr_s1_reg;
      in_s1_reg   <= array_pin_in;
      in_s2_reg   <= in_s1_reg;
    end
  end

  // ************************************************************
  // Configuration storage
  // ************************************************************
  logic [31:0] gcfg_reg;
  logic [31:0] mc_cfg_reg  [NUM_MC];
  logic [31:0] pt_true_reg [NUM_PT];
  logic [31:0] pt_comp_reg [NUM_PT];

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic        aw_hold_reg;
  logic [11:0] waddr_reg;
  logic        w_hold_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  wire        aw_take  = s_axi_awvalid & ~aw_hold_reg;
  wire        w_take   = s_axi_wvalid & ~w_hold_reg;
  wire        do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire [6:0]  wr_idx   = waddr_reg[9:3];
  wire [3:0]  wr_mc    = waddr_reg[5:2];
  wire        wr_g     = waddr_reg == GLOBAL_CFG_OFF;
  wire        wr_c     = waddr_reg[11:6] == MC_CFG_PAGE;
  wire        wr_p     = (waddr_reg[11:10] == PT_PAGE) && (int'(wr_idx) < NUM_PT);
  wire        wr_hit   = wr_g | wr_c | wr_p;
  wire [31:0] bmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                          {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      waddr_reg   <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_hold_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold_reg <= 1'b0;
      if (w_take)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold_reg <= 1'b0;
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Register file updates
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gcfg_reg <= GLOBAL_CFG_RST;
      for (int i = 0; i < NUM_MC; i++)
        mc_cfg_reg[i] <= MC_CFG_RST;
      for (int i = 0; i < NUM_PT; i++)
      begin
        pt_true_reg[i] <= PT_MASK_RST;
        pt_comp_reg[i] <= PT_MASK_RST;
      end
    end
    else if (do_write)
    begin
      if (wr_g)
        gcfg_reg <= merge(gcfg_reg, wdata_reg, bmask);
      if (wr_c)
        mc_cfg_reg[wr_mc] <= merge(mc_cfg_reg[wr_mc], wdata_reg, bmask);
      if (wr_p && !waddr_reg[2])
        pt_true_reg[wr_idx] <= merge(pt_true_reg[wr_idx], wdata_reg, bmask);
      if (wr_p && waddr_reg[2])
        pt_comp_reg[wr_idx] <= merge(pt_comp_reg[wr_idx], wdata_reg, bmask);
    end
  end

  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready  = ~w_hold_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // ************************************************************
  // Global clock nets
  // ************************************************************
  logic [1:0] net_prev_reg;

  wire        net0_src  = gcfg_reg[NET0_PIN_BIT] ? gpin_s2_reg[1] : gpin_s2_reg[0];
  wire        net1_src  = gcfg_reg[NET1_PIN_BIT] ? gpin_s2_reg[1] : gpin_s2_reg[0];
  wire [1:0]  net_lvl   = {net1_src ^ gcfg_reg[NET1_INV_BIT],
                           net0_src ^ gcfg_reg[NET0_INV_BIT]};
  wire [1:0]  gclk_rise = net_lvl & ~net_prev_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      net_prev_reg <= 2'h0;
    else
      net_prev_reg <= net_lvl;
  end

  // ************************************************************
  // Logic array product terms
  // ************************************************************
  logic [15:0]        share_fb_reg;
  logic [15:0]        share_out;
  logic [NUM_PT-1:0]  pt_val;
  wire  [NUM_LIT-1:0] lits = {share_fb_reg, in_s2_reg};

  // Registered feedback keeps expander loops from closing combinationally
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      share_fb_reg <= 16'h0000;
    else
      share_fb_reg <= share_out;
  end

  // Empty term masks give an unused, low term
  for (genvar e = 0; e < NUM_PT; e++)
  begin : g_pt
    assign pt_val[e] = (|(pt_true_reg[e] | pt_comp_reg[e]))
                       & (&(lits | ~pt_true_reg[e]))
                       & (&(~lits | ~pt_comp_reg[e]));
  end

  // ************************************************************
  // Expander chains and macrocells
  // ************************************************************
  logic [15:0] lend_en;
  logic [15:0] lend_or;
  logic [15:0] borrow_in;
  logic [15:0] ff_q;
  logic [31:0] exp_delay;
  logic [1:0]  depth_eff [NUM_MC];

  for (genvar k = 0; k < NUM_MC; k++)
  begin : g_mc
    localparam int POS = k % CHAIN_LEN;
    wire [1:0] depth_raw = mc_cfg_reg[k][DEPTH_LSB +: 2];
    logic [MAX_SETS-1:0] bor;

    // Chain ends: bottom never borrows, top never lends
    assign lend_en[k]   = mc_cfg_reg[k][LEND_BIT] & (POS != CHAIN_LEN - 1);
    assign depth_eff[k] = (POS == 0) ? 2'h0 :
                          (int'(depth_raw) > POS) ? 2'(POS) : depth_raw;
    assign exp_delay[2*k +: 2] = depth_eff[k];

    for (genvar j = 1; j <= MAX_SETS; j++)
    begin : g_set
      if (j <= POS)
      begin : g_ok
        assign bor[j-1] = (&lend_en[k-j +: j]) && (int'(depth_eff[k]) >= j)
                          && lend_or[k-j];
      end
      else
      begin : g_none
        assign bor[j-1] = 1'b0;
      end
    end
    assign borrow_in[k] = |bor;

    mlc_macrocell u_mc (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .pt            (pt_val[k*PT_PER_MC +: PT_PER_MC]),
      .cfg           (mc_cfg_reg[k]),
      .lend_en       (lend_en[k]),
      .borrow_in     (borrow_in[k]),
      .gclk_rise     (gclk_rise),
      .gclr_low_sync (gclr_s2_reg),
      .lend_or       (lend_or[k]),
      .share_out     (share_out[k]),
      .out_reg       (mc_out[k]),
      .q_reg         (ff_q[k])
    );
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire        ar_take = s_axi_arvalid & ~rvalid_reg;
  wire [11:0] ra      = s_axi_araddr;
  wire [6:0]  rd_idx  = ra[9:3];
  wire        rd_g    = ra == GLOBAL_CFG_OFF;
  wire        rd_o    = ra == OUT_STAT_OFF;
  wire        rd_f    = ra == FF_STAT_OFF;
  wire        rd_e    = ra == EXP_DELAY_OFF;
  wire        rd_c    = ra[11:6] == MC_CFG_PAGE;
  wire        rd_p    = (ra[11:10] == PT_PAGE) && (int'(rd_idx) < NUM_PT);
  wire        rd_hit  = rd_g | rd_o | rd_f | rd_e | rd_c | rd_p;
  wire [31:0] pt_word = ra[2] ? pt_comp_reg[rd_idx] : pt_true_reg[rd_idx];
  wire [31:0] rd_data = rd_g ? gcfg_reg :
                        rd_o ? {16'h0000, mc_out} :
                        rd_f ? {16'h0000, ff_q} :
                        rd_e ? exp_delay :
                        rd_c ? mc_cfg_reg[ra[5:2]] :
                        rd_p ? pt_word : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_data;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> (ff_q == 16'h0000) && (mc_out == 16'h0000))
    else $error("registers not cleared by reset");
  a_chain_base: assert property (@(posedge aclk) disable iff (!aresetn)
    !borrow_in[0] && !borrow_in[8] && !lend_en[7] && !lend_en[15])
    else $error("chain end misused");
  a_chain_split: assert property (@(posedge aclk) disable iff (!aresetn)
    (depth_eff[8] == 2'h0) && (int'(depth_eff[9]) <= 1))
    else $error("borrow crosses chains");
  a_gclr_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (!gclr_s2_reg && mc_cfg_reg[3][GCLR_EN_BIT]) |=> !ff_q[3])
    else $error("global clear ignored");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  c_deep_borrow: cover property (@(posedge aclk) borrow_in[7] && depth_eff[7] == 2'h3);
  c_write_read: cover property (@(posedge aclk) do_write ##[1:8] ar_take);
endmodule

// File: pkg/mlc_pkg.sv
// Constants and types for the macrocell logic array block
package mlc_pkg;
  localparam int NUM_MC    = 16;
  localparam int PT_PER_MC = 5;
  localparam int NUM_PT    = 80;
  localparam int NUM_LIT   = 32;
  localparam int CHAIN_LEN = 8;
  localparam int MAX_SETS  = 3;
  localparam int MAX_TERMS = 20;
  localparam int ADDR_W    = 12;

  localparam logic [11:0] GLOBAL_CFG_OFF = 12'h000;
  localparam logic [11:0] OUT_STAT_OFF   = 12'h004;
  localparam logic [11:0] FF_STAT_OFF    = 12'h008;
  localparam logic [11:0] EXP_DELAY_OFF  = 12'h00c;
  localparam logic [5:0]  MC_CFG_PAGE    = 6'h01;
  localparam logic [1:0]  PT_PAGE        = 2'h1;

  localparam int NET0_PIN_BIT = 0;
  localparam int NET0_INV_BIT = 1;
  localparam int NET1_PIN_BIT = 2;
  localparam int NET1_INV_BIT = 3;

  localparam int FF_TYPE_LSB  = 0;
  localparam int BYPASS_BIT   = 2;
  localparam int CLK_MODE_LSB = 3;
  localparam int GCLK_NET_BIT = 5;
  localparam int GCLR_EN_BIT  = 6;
  localparam int SHARE_BIT    = 7;
  localparam int LEND_BIT     = 8;
  localparam int DEPTH_LSB    = 9;
  localparam int PU_HIGH_BIT  = 11;
  localparam int SEC_LSB      = 12;
  localparam int XOR_POL_BIT  = 17;

  localparam int PT_ACLK = 0;
  localparam int PT_CE   = 1;
  localparam int PT_PRE  = 2;
  localparam int PT_CLR  = 3;
  localparam int PT_KR   = 4;

  localparam logic [31:0] GLOBAL_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MC_CFG_RST     = 32'h0000_0000;
  localparam logic [31:0] PT_MASK_RST    = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MLC_FF_D  = 2'h0,
    MLC_FF_T  = 2'h1,
    MLC_FF_JK = 2'h2,
    MLC_FF_SR = 2'h3
  } mlc_ff_t;

  typedef enum logic [1:0] {
    MLC_CLK_GLOBAL    = 2'h0,
    MLC_CLK_GLOBAL_CE = 2'h1,
    MLC_CLK_ARRAY     = 2'h2
  } mlc_clk_t;
endpackage

// File: src/mlc_macrocell.sv
// One macrocell: term routing, configurable register, bypass
`timescale 1ns/100ps
module mlc_macrocell
  import mlc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  pt,
  input  wire logic [31:0] cfg,
  input  wire logic        lend_en,
  input  wire logic        borrow_in,
  input  wire logic [1:0]  gclk_rise,
  input  wire logic        gclr_low_sync,
  output logic             lend_or,
  output logic             share_out,
  output logic             out_reg,
  output logic             q_reg
);
  logic       aprev_reg;
  logic       f_log;
  wire  [4:0] sec      = cfg[SEC_LSB +: PT_PER_MC];
  wire        share    = cfg[SHARE_BIT];
  wire        pu_high  = cfg[PU_HIGH_BIT];
  wire        bypass   = cfg[BYPASS_BIT];
  wire  [1:0] clk_mode = cfg[CLK_MODE_LSB +: 2];
  wire  [1:0] ff_type  = cfg[FF_TYPE_LSB +: 2];
  wire  [4:0] prim     = ~sec & ~{share, 4'h0};
  wire        prim_or  = |(pt & prim);
  wire        sum_or   = (lend_en ? 1'b0 : prim_or) | borrow_in;
  wire        d_in     = sum_or ^ cfg[XOR_POL_BIT];
  wire        k_in     = sec[PT_KR] & ~share & pt[PT_KR];
  wire        clr      = (sec[PT_CLR] & pt[PT_CLR])
                         | (cfg[GCLR_EN_BIT] & ~gclr_low_sync);
  wire        pre      = sec[PT_PRE] & pt[PT_PRE];
  wire        aclk_pt  = sec[PT_ACLK] & pt[PT_ACLK];
  wire        g_tick   = gclk_rise[cfg[GCLK_NET_BIT]];
  wire        tick     = (clk_mode == MLC_CLK_GLOBAL) ? g_tick :
                         (clk_mode == MLC_CLK_GLOBAL_CE) ? g_tick & sec[PT_CE] & pt[PT_CE] :
                         (clk_mode == MLC_CLK_ARRAY) ? aclk_pt & ~aprev_reg :
                         1'b0;
  wire        q_log    = pu_high ? ~q_reg : q_reg;
  wire        q_now    = clr ? 1'b0 : (pre ? 1'b1 : q_reg);
  wire        q_next   = clr ? 1'b0 : pre ? 1'b1 :
                         tick ? (pu_high ? ~f_log : f_log) : q_reg;
  wire        out_next = bypass ? d_in : (pu_high ? ~q_now : q_now);

  // Next logical state per register type
  always_comb
  begin
    case (ff_type)
      MLC_FF_D:  f_log = d_in;
      MLC_FF_T:  f_log = q_log ^ d_in;
      MLC_FF_JK: f_log = (d_in & ~q_log) | (~k_in & q_log);
      MLC_FF_SR: f_log = d_in | (~k_in & q_log);
      default:   f_log = d_in;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg     <= 1'b0;
      out_reg   <= 1'b0;
      aprev_reg <= 1'b0;
    end
    else
    begin
      q_reg     <= q_next;
      out_reg   <= out_next;
      aprev_reg <= aclk_pt;
    end
  end

  assign lend_or   = lend_en & prim_or;
  assign share_out = share & ~pt[PT_KR];

  a_clear_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    clr |=> !q_reg) else $error("clear did not win");
  a_preset_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre && !clr && !bypass && !pu_high) |=> out_reg) else $error("preset lost");
  a_d_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && !clr && !pre && ff_type == MLC_FF_D && !pu_high) |=> q_reg == $past(d_in))
    else $error("d capture wrong");
  a_t_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && d_in && !clr && !pre && ff_type == MLC_FF_T) |=> q_reg != $past(q_reg))
    else $error("toggle missed");
  a_hold_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tick && !clr && !pre) |=> $stable(q_reg)) else $error("state moved without clock");
  a_bypass_path: assert property (@(posedge aclk) disable iff (!aresetn)
    bypass |=> out_reg == $past(d_in)) else $error("bypass wrong");
  a_pu_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (pu_high && !bypass && !q_reg && !pre) |=> out_reg) else $error("power-up high wrong");
  c_array_tick: cover property (@(posedge aclk) clk_mode == MLC_CLK_ARRAY && tick);
  c_jk_tick: cover property (@(posedge aclk) ff_type == MLC_FF_JK && tick && k_in);
endmodule

// File: tb/mlc_pin_model.sv
// Pin-side model: global clock, global clear and array input pins
`timescale 1ns/100ps
module mlc_pin_model (
  input  wire logic        aclk,
  output logic             global_clock_pin_a,
  output logic             global_clock_pin_b,
  output logic             global_clear_pin_low,
  output logic [15:0]      array_pin_in
);
  initial
  begin
    global_clock_pin_a   = 1'b0;
    global_clock_pin_b   = 1'b0;
    global_clear_pin_low = 1'b1;
    array_pin_in         = 16'h0000;
  end
  task automatic pin(input int n, input logic v);
    @(posedge aclk);
    array_pin_in[n] <= v;
  endtask
  task automatic clr(input logic v);
    @(posedge aclk);
    global_clear_pin_low <= v;
  endtask
  // Pulse held long enough to pass the synchronisers
  task automatic tick(input logic sel);
    @(posedge aclk);
    if (sel)
      global_clock_pin_b <= 1'b1;
    else
      global_clock_pin_a <= 1'b1;
    repeat (4) @(posedge aclk);
    global_clock_pin_a <= 1'b0;
    global_clock_pin_b <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the macrocell logic array block
`timescale 1ns/100ps
`define CHK(n, a, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s at %h: expected %h seen %h", n, a, e, g); end end
module testbench;
  import mlc_pkg::*;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  awprot, arprot;
  logic        gca, gcb, gclr;
  logic [15:0] apin, mc_out;
  logic [45:0] rq[$], rn;
  logic [13:0] wq[$], wn;
  int          error_cnt, total_checks;

  mlc_pin_model u_pins (.aclk(aclk), .global_clock_pin_a(gca), .global_clock_pin_b(gcb),
    .global_clear_pin_low(gclr), .array_pin_in(apin));

  mlc_lab_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .global_clock_pin_a(gca),
    .global_clock_pin_b(gcb), .global_clear_pin_low(gclr), .array_pin_in(apin),
    .mc_out(mc_out));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int   n;
    logic ad, wd, done;
    wq.push_back({a, r});
    awaddr  <= a;
    awprot  <= 3'($urandom);
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    {ad, wd, done, n} = '0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready && !ad)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
      done = bvalid;
    end while (!done && n < 50);
    if (!done)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int   n;
    logic ad, done;
    rq.push_back({a, r, d});
    araddr  <= a;
    arprot  <= 3'($urandom);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    {ad, done, n} = '0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready && !ad)
      begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
      done = rvalid;
    end while (!done && n < 50);
    if (!done)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Oldest note is compared whenever a response is handed over
  always @(posedge aclk)
  begin
    if (bvalid && bready)
    begin
      wn = wq.pop_front();
      `CHK("write response", wn[13:2], wn[1:0], bresp)
    end
    if (rvalid && rready)
    begin
      rn = rq.pop_front();
      `CHK("read data", rn[45:34], rn[33:0], {rresp, rdata})
    end
  end

  initial
  begin
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, error_cnt, total_checks, awprot, arprot} = '0;
    void'($urandom(32'hf0f83888));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(GLOBAL_CFG_OFF, 32'h0, RESP_OKAY);
    rd(12'h040, 32'h0, RESP_OKAY);
    rd(OUT_STAT_OFF, 32'h0, RESP_OKAY);
    rd(FF_STAT_OFF, 32'h0, RESP_OKAY);
    rd(12'h3f0, 32'h0, RESP_SLVERR);
    wr(12'h3f0, 32'h1, 4'hf, RESP_SLVERR);
    rnd = $urandom;
    wr(12'h054, rnd, 4'hf, RESP_OKAY);
    rd(12'h054, rnd, RESP_OKAY);
    wr(12'h054, 32'h0, 4'h5, RESP_OKAY);
    rd(12'h054, rnd & 32'hff00ff00, RESP_OKAY);
    wr(12'h054, 32'h0, 4'hf, RESP_OKAY);
    // Macrocell 1: D flop on net 1 (pin b), term 1 as clock enable
    wr(GLOBAL_CFG_OFF, 32'h4, 4'hf, RESP_OKAY);
    wr(12'h428, 32'h2, 4'hf, RESP_OKAY);
    wr(12'h430, 32'h2, 4'hf, RESP_OKAY);
    wr(12'h044, 32'h2028, 4'hf, RESP_OKAY);
    u_pins.pin(1, 1'b1);
    u_pins.tick(1'b0);
    rd(FF_STAT_OFF, 32'h0, RESP_OKAY);
    u_pins.tick(1'b1);
    rd(FF_STAT_OFF, 32'h2, RESP_OKAY);
    u_pins.pin(1, 1'b0);
    repeat (3) @(posedge aclk);
    u_pins.tick(1'b1);
    rd(FF_STAT_OFF, 32'h2, RESP_OKAY);
    wr(12'h044, 32'h2068, 4'hf, RESP_OKAY);
    u_pins.clr(1'b0);
    repeat (4) @(posedge aclk);
    rd(FF_STAT_OFF, 32'h0, RESP_OKAY);
    u_pins.clr(1'b1);
    // Macrocell 3: term preset then term clear
    wr(12'h488, 32'h4, 4'hf, RESP_OKAY);
    wr(12'h490, 32'h8, 4'hf, RESP_OKAY);
    wr(12'h04c, 32'hc000, 4'hf, RESP_OKAY);
    u_pins.pin(2, 1'b1);
    repeat (4) @(posedge aclk);
    rd(FF_STAT_OFF, 32'h8, RESP_OKAY);
    u_pins.pin(3, 1'b1);
    repeat (4) @(posedge aclk);
    rd(FF_STAT_OFF, 32'h0, RESP_OKAY);
    // Macrocell 0 bypassed, macrocell 2 powered up high
    wr(12'h400, 32'h1, 4'hf, RESP_OKAY);
    wr(12'h040, 32'h4, 4'hf, RESP_OKAY);
    u_pins.pin(0, 1'b1);
    repeat (4) @(posedge aclk);
    `CHK("mc_out", 12'h0, 1'b1, mc_out[0])
    rd(OUT_STAT_OFF, 32'h1, RESP_OKAY);
    wr(12'h048, 32'h800, 4'hf, RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd(OUT_STAT_OFF, 32'h5, RESP_OKAY);
    // Lending: 0 to 1 counts, 7 to 8 crosses chains and does not
    wr(12'h040, 32'h104, 4'hf, RESP_OKAY);
    wr(12'h044, 32'h226c, 4'hf, RESP_OKAY);
    wr(12'h05c, 32'h100, 4'hf, RESP_OKAY);
    wr(12'h060, 32'h200, 4'hf, RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd(EXP_DELAY_OFF, 32'h4, RESP_OKAY);
    rd(OUT_STAT_OFF, 32'h6, RESP_OKAY);
    // Macrocell 4: T flop on array clock term, XOR polarity drives toggle
    wr(12'h4a0, 32'h10, 4'hf, RESP_OKAY);
    wr(12'h050, 32'h21011, 4'hf, RESP_OKAY);
    u_pins.pin(4, 1'b1);
    repeat (4) @(posedge aclk);
    rd(FF_STAT_OFF, 32'h10, RESP_OKAY);
    u_pins.pin(4, 1'b0);
    repeat (3) @(posedge aclk);
    u_pins.pin(4, 1'b1);
    repeat (4) @(posedge aclk);
    rd(FF_STAT_OFF, 32'h0, RESP_OKAY);
    complete_run();
  end
endmodule
